// file: ppp_regs.svh
// Functional notes
// - Entry pins change within 100 ns refuses
// - Command and address persist across operations
// - Erase clears memories, then lock bits
// - Preserve fuse keeps EEPROM during erase
// - Action 10, select low loads command
// - Erase starts on write strobe, busy
// - Command 0001 0000 selects flash write
// - Action 00 loads low/high/extended address
// - Action 01 loads low or high data
// - Page latch copies data word to buffer
// - Low bits pick word, upper pick page
// - Write strobe programs flash page, busy
// - Command 0000 0000 ends write session
// - Write strobe programs EEPROM page, busy
// - Ready/busy low while operation runs
// - Drive data bus only when enabled
// - Page write busy 3.7 to 4.5 ms
// - Chip erase busy 7.5 to 9 ms
`ifndef PPP_REGS_SVH
`define PPP_REGS_SVH

// Clock period and timing in ns, entry toggle count
`define PPP_CLK_NS        40
`define PPP_ENTRY_HOLD_NS 100
`define PPP_T_PAGE_NS     3700000
`define PPP_T_ERASE_NS    7500000
`define PPP_ENTRY_TOGGLES 3'h6

// Action select codes
`define PPP_XA_ADDR 2'h0
`define PPP_XA_DATA 2'h1
`define PPP_XA_CMD  2'h2

// Byte select codes
`define PPP_BS_LO  2'h0
`define PPP_BS_HI  2'h1
`define PPP_BS_EXT 2'h2

// Command bytes
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_FLASH 8'h10
`define PPP_CMD_EEP   8'h11
`define PPP_CMD_NOOP  8'h00

`endif

// file: ppp_pkg.sv
package ppp_pkg;

  // Operation in progress
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_PAGE  = 2'b01,
    OP_ERASE = 2'b10
  } ppp_op_t;

  // Programming-mode entry state
  typedef enum logic [1:0] {
    EN_OFF  = 2'b00,
    EN_HOLD = 2'b01,
    EN_ON   = 2'b10,
    EN_FAIL = 2'b11
  } ppp_entry_t;

  // Least time in whole cycles, never below one
  function automatic int ppp_cyc_up(input int ns, input int clk_ns);
    int c;
    c = (ns + clk_ns - 1) / clk_ns;
    return (c < 1) ? 1 : c;
  endfunction : ppp_cyc_up

endpackage : ppp_pkg

// file: ppp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,  // System clock
  input  wire logic         rst_b,    // Async reset, active low
  input  wire logic [W-1:0] async_in, // Pins from outside the domain
  output logic      [W-1:0] sync_out  // Synchronised copy
);

  logic [W-1:0] meta_q;  // First stage, read only by the second
  logic [W-1:0] sync_q;  // Second stage

  ////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : ppp_sync
`default_nettype wire

// file: ppp_page_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_page_mem #(
  parameter int W  = 16,
  parameter int AW = 6
) (
  input  wire logic          sys_clk, // System clock
  input  wire logic          rst_b,   // Async reset, active low
  input  wire logic          we,      // Write one word
  input  wire logic [AW-1:0] waddr,   // Word within page
  input  wire logic [W-1:0]  wdata,   // Word to store
  input  wire logic [AW-1:0] raddr,   // Read index
  output logic      [W-1:0]  rdata    // Registered read data
);

  logic [W-1:0] mem [2**AW];  // Page buffer, no reset needed
  logic [W-1:0] rdata_q;      // Read register

  ////////////////////////////////////////////////////////////////////
  // Storage write
  always_ff @(posedge sys_clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Registered read keeps the output on a flop
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= '0;
    else
      rdata_q <= mem[raddr];
  end

  assign rdata = rdata_q;

endmodule : ppp_page_mem
`default_nettype wire

// file: ppp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppp_regs.svh"
module ppp_port
  import ppp_pkg::*;
#(
  parameter int WORD_BITS   = 6,   // Flash words per page, as log2
  parameter int EE_BITS     = 2,   // EEPROM bytes per page, as log2
  parameter int PAGE_WR_CYC = ppp_cyc_up(`PPP_T_PAGE_NS, `PPP_CLK_NS),
  parameter int ERASE_CYC   = ppp_cyc_up(`PPP_T_ERASE_NS, `PPP_CLK_NS)
) (
  input  wire logic                 sys_clk,              // 25 MHz clock
  input  wire logic                 rst_b,                // Async reset
  input  wire logic                 prog_hv,              // Reset pin at high voltage
  input  wire logic                 load_strobe,          // Load pulse pin
  input  wire logic                 action_select_hi,     // Action select bit 1
  input  wire logic                 action_select_lo,     // Action select bit 0
  input  wire logic                 byte_select_one,      // Byte select 1
  input  wire logic                 byte_select_two,      // Byte select 2
  input  wire logic                 page_latch_strobe,    // Page latch pin
  input  wire logic                 write_strobe_b,       // Write pulse, low
  input  wire logic                 out_enable_b,         // Output enable, low
  input  wire logic [7:0]           data_in,              // Data bus input
  output logic      [7:0]           data_out,             // Data bus output
  output logic                      data_oe,              // Data bus drive enable
  output logic                      ready_busy_flag,      // 1 ready, 0 busy
  input  wire logic                 eeprom_preserve_fuse, // Keep EEPROM on erase
  output logic                      prog_mode,            // Programming mode on
  output logic                      entry_refused,        // Entry was refused
  output logic                      page_commit,          // Page write start pulse
  output logic                      commit_eeprom,        // Commit is EEPROM page
  output logic      [23:0]          commit_addr,          // Address at commit
  output logic                      erase_flash,          // Flash erase pulse
  output logic                      erase_eeprom,         // EEPROM erase pulse
  output logic                      clear_lock,           // Lock clear pulse
  input  wire logic [WORD_BITS-1:0] buf_rd_idx,           // Buffer read index
  output logic      [15:0]          buf_rd_data           // Buffer read data
);

  ////////////////////////////////////////////////////////////////////
  // Elaboration checks and derived constants
  localparam int HOLD_CYC = ppp_cyc_up(`PPP_ENTRY_HOLD_NS, `PPP_CLK_NS);
  localparam int MAX_CYC  = (ERASE_CYC > PAGE_WR_CYC) ? ERASE_CYC : PAGE_WR_CYC;
  localparam int TW       = $clog2(MAX_CYC + 1);

  if (WORD_BITS < 1 || WORD_BITS > 8 || EE_BITS < 1 || EE_BITS > WORD_BITS)
  begin : g_bad_page
    $error("ppp_port: page size not supported");
  end
  if (PAGE_WR_CYC < 1 || ERASE_CYC < 1)
  begin : g_bad_time
    $error("ppp_port: busy times must be positive");
  end

  // True for commands that the write strobe acts on
  function automatic logic is_write_cmd(input logic [7:0] c);
    return (c == `PPP_CMD_ERASE) || (c == `PPP_CMD_FLASH) || (c == `PPP_CMD_EEP);
  endfunction : is_write_cmd

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisation; all pins share one latency so data and
  // strobes stay aligned as they were on the pins
  logic [16:0] pins_s;  // Synchronised pins
  ppp_sync #(.W(17)) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in ({prog_hv, load_strobe, action_select_hi, action_select_lo,
                byte_select_one, byte_select_two, page_latch_strobe,
                write_strobe_b, out_enable_b, data_in}),
    .sync_out (pins_s)
  );

  wire       hv_s  = pins_s[16];               // High voltage present
  wire       ls_s  = pins_s[15];               // Load strobe
  wire [1:0] xa_s  = pins_s[14:13];            // Action select
  wire       bs1_s = pins_s[12];               // Byte select 1
  wire [1:0] bs_s  = {pins_s[11], pins_s[12]}; // Byte select pair
  wire       pl_s  = pins_s[10];               // Page latch
  wire       wr_s  = pins_s[9];                // Write strobe, low
  wire       oe_s  = pins_s[8];                // Output enable, low
  wire [7:0] din_s = pins_s[7:0];              // Data bus
  wire [3:0] sel_s = {pl_s, xa_s, bs1_s};      // Entry-select pins

  ////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised strobes
  logic ls_q;  // Previous load strobe
  logic pl_q;  // Previous page latch
  logic wr_q;  // Previous write strobe
  logic hv_q;  // Previous high voltage

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ls_q <= 1'b0;
      pl_q <= 1'b0;
      wr_q <= 1'b0;
      hv_q <= 1'b0;
    end
    else
    begin
      ls_q <= ls_s;
      pl_q <= pl_s;
      wr_q <= wr_s;
      hv_q <= hv_s;
    end
  end

  wire ls_rise = ls_s & ~ls_q;
  wire pl_rise = pl_s & ~pl_q;
  wire wr_fall = ~wr_s & wr_q;
  wire hv_rise = hv_s & ~hv_q;

  ////////////////////////////////////////////////////////////////////
  // Programming-mode entry
  ppp_entry_t en_q;    // Entry state
  ppp_entry_t en_d;
  logic [2:0] tog_q;   // Load strobe toggles seen while in reset
  logic [3:0] sel_q;   // Entry pins captured at voltage rise
  logic [7:0] hold_q;  // Cycles left in the quiet window

  wire tog_ok   = (tog_q >= `PPP_ENTRY_TOGGLES);
  wire sel_ok   = (sel_s == 4'h0);
  wire sel_move = (sel_s != sel_q);
  wire prog_on  = (en_q == EN_ON);

  // Next entry state; voltage loss always drops back to off
  always_comb
  begin
    en_d = en_q;
    case (en_q)
      EN_OFF:  if (hv_rise) en_d = (tog_ok && sel_ok) ? EN_HOLD : EN_FAIL;
      EN_HOLD: if (sel_move) en_d = EN_FAIL;
               else if (hold_q == 8'h0) en_d = EN_ON;
      EN_ON:   en_d = EN_ON;
      EN_FAIL: en_d = EN_FAIL;
      default: en_d = EN_OFF;
    endcase
    if (!hv_s)
      en_d = EN_OFF;
  end

  // Toggle count saturates; only counted while the reset pin is low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_q   <= EN_OFF;
      tog_q  <= 3'h0;
      sel_q  <= 4'h0;
      hold_q <= 8'h0;
    end
    else
    begin
      en_q <= en_d;
      if (hv_s)
        tog_q <= tog_q;
      else if (ls_rise && !tog_ok)
        tog_q <= tog_q + 3'h1;
      if (hv_rise)
      begin
        sel_q  <= sel_s;
        hold_q <= 8'(HOLD_CYC - 1);
      end
      else if (en_q == EN_HOLD && hold_q != 8'h0)
        hold_q <= hold_q - 8'h1;
      if (en_d == EN_OFF && hv_q && !hv_s)
        tog_q <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command, address and data loading
  ppp_op_t     op_q;     // Operation in progress
  logic        rdy_q;    // Ready flag
  logic [7:0]  cmd_q;    // Last command byte
  logic [23:0] addr_q;   // Extended, high, low address
  logic [7:0]  dlo_q;    // Data low latch
  logic [7:0]  dhi_q;    // Data high latch

  // Loads are refused while busy so the running job sees stable state
  wire ld_ok   = prog_on & ls_rise & rdy_q;
  wire ld_cmd  = ld_ok & (xa_s == `PPP_XA_CMD) & ~bs1_s;
  wire ld_addr = ld_ok & (xa_s == `PPP_XA_ADDR);
  wire ld_data = ld_ok & (xa_s == `PPP_XA_DATA);

  // Registers hold until reloaded; one command serves many words
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_q  <= `PPP_CMD_NOOP;
      addr_q <= 24'h0;
      dlo_q  <= 8'h0;
      dhi_q  <= 8'h0;
    end
    else
    begin
      if (ld_cmd)
        cmd_q <= din_s;
      if (ld_addr && bs_s == `PPP_BS_LO)
        addr_q[7:0] <= din_s;
      if (ld_addr && bs_s == `PPP_BS_HI)
        addr_q[15:8] <= din_s;
      if (ld_addr && bs_s == `PPP_BS_EXT)
        addr_q[23:16] <= din_s;
      if (ld_data && !bs1_s)
        dlo_q <= din_s;
      if (ld_data && bs1_s)
        dhi_q <= din_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Page buffer
  wire is_flash = (cmd_q == `PPP_CMD_FLASH);
  wire is_eep   = (cmd_q == `PPP_CMD_EEP);
  wire is_erase = (cmd_q == `PPP_CMD_ERASE);

  // Word within page; EEPROM pages use fewer low address bits
  wire [WORD_BITS-1:0] widx = is_eep ?
    WORD_BITS'(addr_q[EE_BITS-1:0]) : addr_q[WORD_BITS-1:0];
  wire [15:0] wword = is_eep ? {8'h0, dlo_q} : {dhi_q, dlo_q};
  wire        buf_we = prog_on & pl_rise & bs1_s & rdy_q
                     & (is_flash | is_eep);

  ppp_page_mem #(.W(16), .AW(WORD_BITS)) u_mem (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .we      (buf_we),
    .waddr   (widx),
    .wdata   (wword),
    .raddr   (buf_rd_idx),
    .rdata   (buf_rd_data)
  );

  ////////////////////////////////////////////////////////////////////
  // Write strobe: erase or page program, with busy timing
  logic [TW-1:0] tmr_q;    // Busy cycles left
  logic          pc_q;     // Page commit pulse
  logic          pce_q;    // Commit is EEPROM
  logic [23:0]   pca_q;    // Commit address
  logic          efl_q;    // Flash erase pulse
  logic          eep_q;    // EEPROM erase pulse
  logic          clk_q;    // Lock clear pulse

  // A no-op command leaves no write command, so the strobe is inert
  wire wr_go    = prog_on & wr_fall & rdy_q & (bs_s == `PPP_BS_LO)
                & is_write_cmd(cmd_q);
  wire tmr_done = (tmr_q == '0);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_q  <= OP_IDLE;
      rdy_q <= 1'b1;
      tmr_q <= '0;
      pc_q  <= 1'b0;
      pce_q <= 1'b0;
      pca_q <= 24'h0;
      efl_q <= 1'b0;
      eep_q <= 1'b0;
      clk_q <= 1'b0;
    end
    else
    begin
      pc_q  <= 1'b0;
      efl_q <= 1'b0;
      eep_q <= 1'b0;
      clk_q <= 1'b0;
      if (wr_go && is_erase)
      begin
        op_q  <= OP_ERASE;
        rdy_q <= 1'b0;
        tmr_q <= TW'(ERASE_CYC - 1);
        efl_q <= 1'b1;
        eep_q <= ~eeprom_preserve_fuse;
      end
      else if (wr_go)
      begin
        op_q  <= OP_PAGE;
        rdy_q <= 1'b0;
        tmr_q <= TW'(PAGE_WR_CYC - 1);
        pc_q  <= 1'b1;
        pce_q <= is_eep;
        pca_q <= addr_q;
      end
      else if (!rdy_q && tmr_done)
      begin
        op_q  <= OP_IDLE;
        rdy_q <= 1'b1;
        clk_q <= (op_q == OP_ERASE);
      end
      else if (!rdy_q)
        tmr_q <= tmr_q - TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data bus drive: echoes the selected data latch
  logic       oe_q;   // Bus drive enable
  logic [7:0] dout_q; // Bus output byte

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      oe_q   <= 1'b0;
      dout_q <= 8'h0;
    end
    else
    begin
      oe_q   <= prog_on & ~oe_s;
      dout_q <= bs1_s ? dhi_q : dlo_q;
    end
  end

  assign data_out        = dout_q;
  assign data_oe         = oe_q;
  assign ready_busy_flag = rdy_q;
  assign page_commit     = pc_q;
  assign commit_eeprom   = pce_q;
  assign commit_addr     = pca_q;
  assign erase_flash     = efl_q;
  assign erase_eeprom    = eep_q;
  assign clear_lock      = clk_q;

  // Mode flags registered from the entry state
  logic pm_q;  // Mode on
  logic rf_q;  // Entry refused
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pm_q <= 1'b0;
      rf_q <= 1'b0;
    end
    else
    begin
      pm_q <= (en_d == EN_ON);
      rf_q <= (en_d == EN_FAIL);
    end
  end
  assign prog_mode     = pm_q;
  assign entry_refused = rf_q;

  ////////////////////////////////////////////////////////////////////
  // Checks
  logic [TW:0] len_q;  // Busy length seen so far
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      len_q <= '0;
    else
      len_q <= rdy_q ? '0 : len_q + (TW+1)'(1);
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_erase_go;
    wr_go && is_erase;
  endsequence
  sequence s_erase_busy;
    !rdy_q && op_q == OP_ERASE;
  endsequence

  erase_start_a: assert property (s_erase_go |=> s_erase_busy ##0 efl_q)
    else $error("erase did not start busy");
  busy_len_a: assert property ($rose(rdy_q) |-> len_q == (TW+1)'(
      ($past(op_q) == OP_ERASE) ? ERASE_CYC : PAGE_WR_CYC))
    else $error("busy time wrong");
  erase_fuse_a: assert property (s_erase_go ##1 $past(eeprom_preserve_fuse)
      |-> !eep_q)
    else $error("EEPROM erased under preserve fuse");
  lock_after_a: assert property (clk_q |-> rdy_q && $past(op_q) == OP_ERASE)
    else $error("lock cleared early");
  busy_ignore_a: assert property (!rdy_q |=> $stable(cmd_q) && $stable(addr_q))
    else $error("load taken while busy");
  cmd_keep_a: assert property (!ld_cmd |=> $stable(cmd_q))
    else $error("command changed without load");
  addr_hi_a: assert property (ld_addr && bs_s == `PPP_BS_HI
      |=> addr_q[15:8] == $past(din_s))
    else $error("address high byte not loaded");
  data_lo_a: assert property (ld_data && !bs1_s |=> dlo_q == $past(din_s))
    else $error("data low byte not loaded");
  entry_fail_a: assert property (en_q == EN_HOLD && sel_move && hv_s
      |=> en_q == EN_FAIL)
    else $error("entry not refused");
  bus_drive_a: assert property (oe_q |-> $past(prog_on) && !$past(oe_s))
    else $error("bus driven while disabled");
  noop_inert_a: assert property (cmd_q == `PPP_CMD_NOOP && rdy_q |=> rdy_q && !pc_q)
    else $error("write acted after no-op");

endmodule : ppp_port
`default_nettype wire

// file: ppp_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_prog_model (
  input  wire logic       sys_clk,           // Bench clock paces the pins
  input  wire logic [7:0] dev_out,           // Device bus output
  input  wire logic       dev_oe,            // Device drives the bus
  output logic            prog_hv,           // High voltage on reset pin
  output logic            load_strobe,       // Load pulse, 320 ns period in entry
  output logic            action_select_hi,  // Action bit 1
  output logic            action_select_lo,  // Action bit 0
  output logic            byte_select_one,   // Byte select 1
  output logic            byte_select_two,   // Byte select 2
  output logic            page_latch_strobe, // Page latch pulse
  output logic            write_strobe_b,    // Write pulse, low
  output logic            out_enable_b,      // Output enable, low
  output logic      [7:0] data_in            // Resolved bus level
);
  logic       hv_r;  // Requested high voltage
  logic       ls_r;  // Requested load strobe
  logic [1:0] act_r; // Requested action code, {hi, lo}
  logic [1:0] bs_r;  // Requested byte selects, {two, one}
  logic       pl_r;  // Requested page latch
  logic       wr_r;  // Requested write strobe, low
  logic       oe_r;  // Requested output enable, low
  logic [7:0] dr_r;  // Requested bus value
  logic [7:0] drv_q; // Value the programmer puts on the bus
  initial
  begin
    {hv_r, ls_r, act_r, bs_r, pl_r} = 7'h00;
    {wr_r, oe_r} = 2'b11;
    dr_r = 8'h00;
  end
  // Pins follow the requests one edge later, all together, so their spacing holds
  always @(posedge sys_clk)
  begin
    prog_hv                              <= hv_r;
    load_strobe                          <= ls_r;
    {action_select_hi, action_select_lo} <= act_r;
    {byte_select_two, byte_select_one}   <= bs_r;
    page_latch_strobe                    <= pl_r;
    write_strobe_b                       <= wr_r;
    out_enable_b                         <= oe_r;
    drv_q                                <= dr_r;
  end
  // Programmer lets go while output enable is low; a floating bus shows garbage
  assign data_in = dev_oe ? dev_out : (out_enable_b ? drv_q : ~drv_q);
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : step
  // Entry: toggles with reset low, pins 0000, settle, then high voltage
  task automatic entry(input bit wiggle);
    hv_r <= 1'b0;
    repeat (6)
    begin
      step(4);
      ls_r <= 1'b1;
      step(4);
      ls_r <= 1'b0;
    end
    {pl_r, act_r, bs_r[0]} <= 4'h0;
    step(4);
    hv_r <= 1'b1;
    step(1);
    if (wiggle) act_r[0] <= 1'b1;
    step(2);
    act_r[0] <= 1'b0;
    step(20);
  endtask : entry
  // One load: strobe stands still outside loads, data held over the whole pulse
  task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
    act_r <= act;
    bs_r  <= bs;
    dr_r  <= d;
    step(2);
    ls_r <= 1'b1;
    step(4);
    ls_r <= 1'b0;
    step(4);
  endtask : load
  task automatic latch();
    bs_r[0] <= 1'b1;
    step(2);
    pl_r <= 1'b1;
    step(4);
    pl_r <= 1'b0;
    step(4);
  endtask : latch
  task automatic wr(input logic [1:0] bs);
    bs_r <= bs;
    step(2);
    wr_r <= 1'b0;
    step(4);
    wr_r <= 1'b1;
    step(2);
  endtask : wr
  // Readback: output enable low with the low latch selected, or released again
  task automatic read_bus(input bit on);
    oe_r    <= ~on;
    bs_r[0] <= 1'b0;
    step(6);
  endtask : read_bus
endmodule : ppp_prog_model
`default_nettype wire

// file: tb_parallel_program_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_program_port;
  import ppp_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, fuse = 1'b0;
  logic [5:0] idx = 6'h00;
  wire logic [7:0] d_in, d_out;
  wire logic oe, rdy, pmode, refused, pc, ce, efl, eee, clk_l, hv, ls, xh, xl, b1, b2, pl, wrb, oeb;
  wire logic [23:0] caddr;
  wire logic [15:0] bdata;
  int mismatches = 0, checks_done = 0, n_pc, n_ef, n_ee, n_cl, run, last_len;
  always #20 sys_clk = ~sys_clk;
  ppp_port #(.PAGE_WR_CYC(60), .ERASE_CYC(120)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .prog_hv(hv), .load_strobe(ls),
    .action_select_hi(xh), .action_select_lo(xl), .byte_select_one(b1),
    .byte_select_two(b2), .page_latch_strobe(pl), .write_strobe_b(wrb),
    .out_enable_b(oeb), .data_in(d_in), .data_out(d_out), .data_oe(oe),
    .ready_busy_flag(rdy), .eeprom_preserve_fuse(fuse), .prog_mode(pmode),
    .entry_refused(refused), .page_commit(pc), .commit_eeprom(ce),
    .commit_addr(caddr), .erase_flash(efl), .erase_eeprom(eee), .clear_lock(clk_l),
    .buf_rd_idx(idx), .buf_rd_data(bdata));
  ppp_prog_model i_prog (
    .sys_clk(sys_clk), .dev_out(d_out), .dev_oe(oe), .prog_hv(hv), .load_strobe(ls),
    .action_select_hi(xh), .action_select_lo(xl), .byte_select_one(b1),
    .byte_select_two(b2), .page_latch_strobe(pl), .write_strobe_b(wrb),
    .out_enable_b(oeb), .data_in(d_in));
  ////////////////////////////////////////////////////////////////////////////
  // Pulse tallies and length of the last busy stretch
  always @(posedge sys_clk)
  begin
    if (pc === 1'b1) n_pc++;
    if (efl === 1'b1) n_ef++;
    if (eee === 1'b1) n_ee++;
    if (clk_l === 1'b1) n_cl++;
    if (rdy === 1'b0) run++;
    else if (run != 0)
    begin
      last_len = run;
      run = 0;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Bounded wait for ready, then one edge so the tallies settle
  task automatic wait_ready();
    int i;
    for (i = 0; i < 400 && rdy !== 1'b1; i++) @(posedge sys_clk);
    if (i >= 400)
    begin
      mismatches++;
      give_verdict();
    end
    @(posedge sys_clk);
  endtask : wait_ready
  task automatic clr();
    {n_pc, n_ef, n_ee, n_cl} = '0;
  endtask : clr
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {n_pc, n_ef, n_ee, n_cl, run, last_len} = '0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk(rdy, 1'b1);
    chk({pmode, oe}, 2'b00);
    // Pins moving right after high voltage must refuse entry
    i_prog.entry(1'b1);
    chk({refused, pmode}, 2'b10);
    i_prog.entry(1'b0);
    chk({refused, pmode}, 2'b01);
    i_prog.step(1250);
    // Erase with the preserve fuse off and then on
    for (int f = 0; f < 2; f++)
    begin
      fuse <= f[0];
      clr();
      i_prog.load(2'b10, 2'b00, 8'h80);
      i_prog.wr(2'b00);
      wait_ready();
      chk(n_ef, 1);
      chk(n_ee, (f == 0));
      chk(n_cl, 1);
      chk(last_len, 120);
    end
    // Flash page: two words under one command, full address
    clr();
    i_prog.load(2'b10, 2'b00, 8'h10);
    i_prog.load(2'b00, 2'b10, 8'h01);
    i_prog.load(2'b00, 2'b01, 8'h12);
    i_prog.load(2'b00, 2'b00, 8'hc5);
    i_prog.load(2'b01, 2'b00, 8'h34);
    i_prog.load(2'b01, 2'b01, 8'hab);
    i_prog.latch();
    i_prog.load(2'b00, 2'b00, 8'hc6);
    i_prog.load(2'b01, 2'b00, 8'h78);
    i_prog.load(2'b01, 2'b01, 8'h56);
    i_prog.latch();
    idx <= 6'h05;
    i_prog.step(4);
    chk(bdata, 16'hab34);
    idx <= 6'h06;
    i_prog.step(4);
    chk(bdata, 16'h5678);
    i_prog.wr(2'b00);
    i_prog.load(2'b10, 2'b00, 8'h80);
    wait_ready();
    chk({ce, caddr}, {1'b0, 24'h0112c6});
    chk(last_len, 60);
    i_prog.wr(2'b00);
    wait_ready();
    chk(n_pc, 2);
    chk(n_ef, 0);
    // Readback drives the bus only while output enable is low
    i_prog.read_bus(1'b1);
    chk({oe, d_in}, {1'b1, 8'h78});
    i_prog.read_bus(1'b0);
    chk(oe, 1'b0);
    // Write with a non-zero byte select is inert
    i_prog.wr(2'b10);
    i_prog.step(10);
    chk(n_pc, 2);
    chk(rdy, 1'b1);
    // EEPROM page
    i_prog.load(2'b10, 2'b00, 8'h11);
    i_prog.load(2'b00, 2'b01, 8'h01);
    i_prog.load(2'b00, 2'b00, 8'h0b);
    i_prog.load(2'b01, 2'b00, 8'h5a);
    i_prog.latch();
    idx <= 6'h03;
    i_prog.step(4);
    chk(bdata[7:0], 8'h5a);
    i_prog.wr(2'b00);
    wait_ready();
    chk({ce, caddr}, {1'b1, 24'h01010b});
    chk(last_len, 60);
    // No-operation ends the session: write strobe does nothing
    i_prog.load(2'b10, 2'b00, 8'h00);
    i_prog.wr(2'b00);
    i_prog.step(10);
    chk(n_pc, 3);
    chk(rdy, 1'b1);
    give_verdict();
  end
endmodule : tb_parallel_program_port
`default_nettype wire
